// >>> src/trap_pkg.sv
// constants shared by the trap unit
package trap_pkg;
  // *****************************************************
  // register map
  // *****************************************************
  localparam logic [15:0] TFR_ADDR  = 16'hFFAC;
  localparam logic [15:0] STAT_ADDR = 16'hFFB0;
  localparam logic [15:0] TFR_RST   = 16'h0000;
  localparam logic [15:0] TFR_MASK  = 16'hE08F;
  // *****************************************************
  // flag positions
  // *****************************************************
  localparam int NMI_BIT = 15;
  localparam int OVF_BIT = 14;
  localparam int UNF_BIT = 13;
  localparam int UND_BIT = 7;
  localparam int PRT_BIT = 3;
  localparam int OPA_BIT = 2;
  localparam int INA_BIT = 1;
  localparam int BUS_BIT = 0;
  // *****************************************************
  // vectors, priority, bus type
  // *****************************************************
  localparam logic [8:0] VEC_NMI   = 9'h008;
  localparam logic [8:0] VEC_OVF   = 9'h010;
  localparam logic [8:0] VEC_UNF   = 9'h018;
  localparam logic [8:0] VEC_CLSB  = 9'h028;
  localparam logic [3:0] PRIO_MAX  = 4'hF;
  localparam logic [1:0] BUS_NONE  = 2'h0;
  localparam logic [7:0] KIND_RST  = 8'h00;
  // handler level, one-hot
  typedef enum logic [3:0] {
    LVL_IDLE = 4'b0001,
    LVL_B    = 4'b0010,
    LVL_A    = 4'b0100,
    LVL_AB   = 4'b1000
  } lvl_t;
endpackage

// >>> src/cpu_trap_unit.sv
// trap flag register, trap arbitration and trap entry control
`timescale 1ns/1ns
`default_nettype none
// Operation
// RULE_01: software trap number picks vector 0h..1FCh
// RULE_02: software trap stacks state, code segment zero
// RULE_03: software trap keeps priority and request flags
// RULE_04: eight unmaskable hardware traps, complete or cancel
// RULE_05: hardware trap stacks state, priority 15
// RULE_06: class A traps, one priority, own vectors
// RULE_07: class B traps share priority and vector
// RULE_08: flag set on trap, software clears
// RULE_09: flag written to one triggers trap
// RULE_10: class A preempts B, never A
// RULE_11: class A order nmi, overflow, underflow
// RULE_12: class B during A waits, ip lost
// RULE_13: nmi with undefined opcode stacks faulting ip
// RULE_14: flag bit positions 15,14,13,7,3..0
// RULE_15: nmi falling edge, next instruction stacked
// RULE_16: stack below low limit sets overflow
// RULE_17: stack above high limit sets underflow
// RULE_18: undefined opcode stacks its own address
// RULE_19: malformed protected instruction is protection fault
// RULE_20: odd word operand, next instruction stacked
// RULE_21: odd branch stacks the odd target
// RULE_22: external access without bus traps
// RULE_23: reserved flag bits read zero
// RULE_24: software write beats hardware set
// RULE_25: return pops ip, status, code segment
module cpu_trap_unit (
  input  wire logic        clk,             // system clock
  input  wire logic        rstn,            // sync reset, low
  input  wire logic        psel,            // apb select
  input  wire logic        penable,         // apb access phase
  input  wire logic        pwrite,          // apb write
  input  wire logic [15:0] paddr,           // apb byte address
  input  wire logic [31:0] pwdata,          // apb write data
  output logic      [31:0] prdata,          // apb read data
  output logic             pready,          // apb ready
  output logic             pslverr,         // unmapped address
  input  wire logic        nmi_n_pin,       // async nmi pin
  input  wire logic        boundary,        // core may enter trap
  input  wire logic        seg_en,          // segmentation on
  input  wire logic [1:0]  bus_type_field,  // system config bus type
  input  wire logic [15:0] ip_cur,          // current instruction
  input  wire logic [15:0] ip_next,         // following instruction
  input  wire logic [15:0] ip_next2,        // one further
  input  wire logic        sw_trap,         // trap instruction
  input  wire logic [6:0]  trap_num,        // trap number operand
  input  wire logic        ret_handler,     // return_from_handler
  input  wire logic        sp_dec,          // sp decremented
  input  wire logic        sp_inc,          // sp incremented
  input  wire logic        sp_arith,        // by sub or add
  input  wire logic [15:0] sp_new,          // new sp value
  input  wire logic [15:0] stack_low_limit, // overflow limit
  input  wire logic [15:0] stack_high_limit,// underflow limit
  input  wire logic        undef_op,        // invalid opcode
  input  wire logic        prot_instr,      // protected opcode
  input  wire logic [15:0] prot_word1,      // opcode, complement
  input  wire logic [15:0] prot_word2,      // repeat word
  input  wire logic        word_access,     // word operand access
  input  wire logic [15:0] oper_addr,       // operand address
  input  wire logic        branch,          // branch taken
  input  wire logic [15:0] branch_target,   // branch target
  input  wire logic        ext_access,      // external fetch
  output logic             trap_go,         // trap entry pulse
  output logic             trap_hw,         // hardware trap
  output logic [8:0]       trap_vec,        // vector address
  output logic [15:0]      trap_ip,         // ip to stack
  output logic             trap_push_csp,   // stack code segment
  output logic             trap_raise,      // load priority
  output logic [3:0]       trap_prio,       // priority to load
  output logic             trap_cancel,     // cancel instruction
  output logic             ret_go,          // return pulse
  output logic             ret_pop_csp      // pop code segment
);
  // *****************************************************
  // state
  // *****************************************************
  logic [15:0] tfr_ff;
  logic [15:0] nxt_tfr;
  logic [15:0] ev;
  logic [2:0]  nmi_sync_ff;
  logic [15:0] a_ip_ff;
  logic [15:0] b_ip_ff;
  logic        b_fresh_ff;
  logic [7:0]  kind_ff;
  trap_pkg::lvl_t lvl_ff;
  logic        nmi_fall, ovf_ev, unf_ev, prt_ev;
  logic        a_pend, b_pend, take_a, take_b, take_sw, in_a;
  logic        apb_acc, tfr_hit, stat_hit, tfr_wr;
  assign nmi_fall = nmi_sync_ff[2] & ~nmi_sync_ff[1]; // see RULE_15
  assign ovf_ev   = sp_dec & (sp_new < stack_low_limit); // see RULE_16
  assign unf_ev   = sp_inc & (sp_new > stack_high_limit); // see RULE_17
  // complement byte then a doubled opcode must follow
  assign prt_ev   = prot_instr & ((prot_word1[15:8] != ~prot_word1[7:0])
                    | (prot_word2 != {2{prot_word1[7:0]}})); // see RULE_19
  // *****************************************************
  // hardware events into flag positions
  // *****************************************************
  always_comb begin
    ev                     = 16'h0000;
    ev[trap_pkg::NMI_BIT]  = nmi_fall;
    ev[trap_pkg::OVF_BIT]  = ovf_ev;
    ev[trap_pkg::UNF_BIT]  = unf_ev;
    ev[trap_pkg::UND_BIT]  = undef_op; // see RULE_18
    ev[trap_pkg::PRT_BIT]  = prt_ev;
    ev[trap_pkg::OPA_BIT]  = word_access & oper_addr[0]; // see RULE_20
    ev[trap_pkg::INA_BIT]  = branch & branch_target[0]; // see RULE_21
    ev[trap_pkg::BUS_BIT]  = ext_access
                             & (bus_type_field == trap_pkg::BUS_NONE); // see RULE_22
  end
  // nmi pin: two stages, then a third for edge detect
  always_ff @(posedge clk) begin
    if (!rstn) begin
      nmi_sync_ff <= 3'h7;
    end else begin
      nmi_sync_ff <= {nmi_sync_ff[1], nmi_sync_ff[0], nmi_n_pin};
    end
  end
  // *****************************************************
  // apb slave, one wait state
  // *****************************************************
  assign apb_acc  = psel & penable & pready;
  assign tfr_hit  = (paddr == trap_pkg::TFR_ADDR);
  assign stat_hit = (paddr == trap_pkg::STAT_ADDR);
  assign tfr_wr   = apb_acc & pwrite & tfr_hit;
  // ready and read data registered so every output is a flop
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~tfr_hit & ~stat_hit;
      if (tfr_hit) begin
        prdata <= {16'h0000, tfr_ff & trap_pkg::TFR_MASK}; // see RULE_23
      end else if (stat_hit) begin
        prdata <= {28'h0000000, lvl_ff};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end
  // *****************************************************
  // trap flag register
  // *****************************************************
  // the write replaces the whole word, so a set in the same cycle is dropped
  always_comb begin
    if (tfr_wr) begin
      nxt_tfr = pwdata[15:0] & trap_pkg::TFR_MASK; // see RULE_24 RULE_09
    end else begin
      nxt_tfr = tfr_ff | ev; // see RULE_08 RULE_14
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tfr_ff <= trap_pkg::TFR_RST;
    end else begin
      tfr_ff <= nxt_tfr;
    end
  end
  // *****************************************************
  // arbitration
  // *****************************************************
  assign in_a    = (lvl_ff == trap_pkg::LVL_A) | (lvl_ff == trap_pkg::LVL_AB);
  assign a_pend  = |tfr_ff[trap_pkg::NMI_BIT:trap_pkg::UNF_BIT];
  assign b_pend  = tfr_ff[trap_pkg::UND_BIT] | (|tfr_ff[trap_pkg::PRT_BIT:0]);
  // no maskable gate on either class
  assign take_a  = boundary & a_pend & ~in_a; // see RULE_10 RULE_04
  assign take_b  = boundary & b_pend & ~take_a
                   & (lvl_ff == trap_pkg::LVL_IDLE); // see RULE_12 RULE_07
  assign take_sw = sw_trap & ~take_a & ~take_b;
  // stacked ip of the winning class A event
  always_ff @(posedge clk) begin
    if (!rstn) begin
      a_ip_ff <= 16'h0000;
    end else if (nmi_fall) begin
      a_ip_ff <= ip_next; // see RULE_15
    end else if (ovf_ev | unf_ev) begin
      a_ip_ff <= sp_arith ? ip_next2 : ip_next; // see RULE_16 RULE_17
    end
  end
  // class B ip kept only outside class A; inside it the ip is lost
  always_ff @(posedge clk) begin
    if (!rstn) begin
      b_ip_ff    <= 16'h0000;
      b_fresh_ff <= 1'b0;
    end else if (!in_a && (undef_op || prt_ev)) begin
      b_ip_ff    <= ip_cur; // see RULE_18 RULE_19
      b_fresh_ff <= 1'b1;
    end else if (!in_a && branch && branch_target[0]) begin
      b_ip_ff    <= branch_target; // see RULE_21
      b_fresh_ff <= 1'b1;
    end else if (!in_a && |ev[trap_pkg::OPA_BIT:0]) begin
      b_ip_ff    <= ip_next; // see RULE_20 RULE_22
      b_fresh_ff <= 1'b1;
    end else if (take_b || tfr_wr) begin
      b_fresh_ff <= 1'b0;
    end else if (in_a && |ev[trap_pkg::UND_BIT:0]) begin
      b_ip_ff    <= ip_next; // see RULE_12
      b_fresh_ff <= 1'b0;
    end
  end
  // *****************************************************
  // trap entry outputs
  // *****************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      trap_go       <= 1'b0;
      trap_hw       <= 1'b0;
      trap_vec      <= 9'h000;
      trap_ip       <= 16'h0000;
      trap_push_csp <= 1'b0;
      trap_raise    <= 1'b0;
      trap_prio     <= 4'h0;
      trap_cancel   <= 1'b0;
    end else begin
      trap_go       <= take_a | take_b | take_sw;
      trap_hw       <= take_a | take_b;
      trap_push_csp <= seg_en & (take_a | take_b | take_sw); // see RULE_02 RULE_05
      trap_raise    <= take_a | take_b; // see RULE_05 RULE_03
      trap_prio     <= (take_a | take_b) ? trap_pkg::PRIO_MAX : 4'h0;
      trap_cancel   <= take_b & (tfr_ff[trap_pkg::UND_BIT] | tfr_ff[trap_pkg::PRT_BIT]);
      if (take_a) begin
        // coincident class B fault keeps its own ip on the stack
        trap_ip <= b_fresh_ff ? b_ip_ff : a_ip_ff; // see RULE_13
        if (tfr_ff[trap_pkg::NMI_BIT]) begin
          trap_vec <= trap_pkg::VEC_NMI; // see RULE_11 RULE_06
        end else if (tfr_ff[trap_pkg::OVF_BIT]) begin
          trap_vec <= trap_pkg::VEC_OVF;
        end else begin
          trap_vec <= trap_pkg::VEC_UNF;
        end
      end else if (take_b) begin
        trap_ip  <= b_ip_ff;
        trap_vec <= trap_pkg::VEC_CLSB; // see RULE_07
      end else if (take_sw) begin
        trap_ip  <= ip_next;
        trap_vec <= {trap_num, 2'b00}; // see RULE_01
      end
    end
  end
  // *****************************************************
  // handler nesting: kind stack and level
  // *****************************************************
  // one bit per open handler, 1 for hardware; eight deep is plenty
  always_ff @(posedge clk) begin
    if (!rstn) begin
      kind_ff <= trap_pkg::KIND_RST;
    end else if (take_a || take_b || take_sw) begin
      kind_ff <= {kind_ff[6:0], take_a | take_b};
    end else if (ret_handler) begin
      kind_ff <= {1'b0, kind_ff[7:1]};
    end
  end
  // return undoes the entry: ip, status, then code segment
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ret_go      <= 1'b0;
      ret_pop_csp <= 1'b0;
    end else begin
      ret_go      <= ret_handler & ~take_a & ~take_b & ~take_sw;
      ret_pop_csp <= ret_handler & seg_en & ~take_a & ~take_b & ~take_sw; // see RULE_25
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lvl_ff <= trap_pkg::LVL_IDLE;
    end else begin
      case (lvl_ff)
        trap_pkg::LVL_IDLE: begin
          if (take_a) begin
            lvl_ff <= trap_pkg::LVL_A;
          end else if (take_b) begin
            lvl_ff <= trap_pkg::LVL_B;
          end
        end
        trap_pkg::LVL_B: begin
          if (take_a) begin
            lvl_ff <= trap_pkg::LVL_AB; // see RULE_10
          end else if (ret_handler && !take_sw && kind_ff[0]) begin
            lvl_ff <= trap_pkg::LVL_IDLE;
          end
        end
        trap_pkg::LVL_A: begin
          if (ret_handler && !take_sw && kind_ff[0]) begin
            lvl_ff <= trap_pkg::LVL_IDLE;
          end
        end
        trap_pkg::LVL_AB: begin
          if (ret_handler && !take_sw && kind_ff[0]) begin
            lvl_ff <= trap_pkg::LVL_B;
          end
        end
        default: begin
          lvl_ff <= trap_pkg::LVL_IDLE;
        end
      endcase
    end
  end
  // *****************************************************
  // assertions
  // *****************************************************
  sequence s_nmi_edge;
    nmi_fall && !tfr_wr;
  endsequence
  sequence s_hw_entry;
    trap_go && trap_hw;
  endsequence
  property p_nmi_flag;
    @(posedge clk) disable iff (!rstn)
      s_nmi_edge |=> tfr_ff[trap_pkg::NMI_BIT];
  endproperty
  a_nmi_flag: assert property (p_nmi_flag) else $error("nmi edge lost"); // see RULE_15
  property p_hw_prio;
    @(posedge clk) disable iff (!rstn)
      s_hw_entry |-> trap_raise && trap_prio == trap_pkg::PRIO_MAX;
  endproperty
  a_hw_prio: assert property (p_hw_prio) else $error("hw trap prio"); // see RULE_05
  property p_sw_entry;
    @(posedge clk) disable iff (!rstn)
      take_sw |=> trap_go && !trap_raise
                  && trap_vec == {$past(trap_num), 2'b00};
  endproperty
  a_sw_entry: assert property (p_sw_entry) else $error("sw trap entry"); // see RULE_01
  property p_a_order;
    @(posedge clk) disable iff (!rstn)
      (s_hw_entry and (trap_vec == trap_pkg::VEC_UNF))
      |-> $past(tfr_ff[trap_pkg::NMI_BIT:trap_pkg::OVF_BIT]) == 2'b00;
  endproperty
  a_a_order: assert property (p_a_order) else $error("class a order"); // see RULE_11
  property p_no_a_in_a;
    @(posedge clk) disable iff (!rstn)
      in_a ##1 s_hw_entry |-> trap_vec == trap_pkg::VEC_CLSB || !$past(in_a);
  endproperty
  a_no_a_in_a: assert property (p_no_a_in_a) else $error("a over a"); // see RULE_10
  property p_b_wait;
    @(posedge clk) disable iff (!rstn)
      in_a |=> not (s_hw_entry and (trap_vec == trap_pkg::VEC_CLSB));
  endproperty
  a_b_wait: assert property (p_b_wait) else $error("b served in a"); // see RULE_12
  property p_rsvd_zero;
    @(posedge clk) disable iff (!rstn)
      (tfr_ff & ~trap_pkg::TFR_MASK) == 16'h0000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved set"); // see RULE_23
  property p_wr_wins;
    @(posedge clk) disable iff (!rstn)
      tfr_wr |=> tfr_ff == ($past(pwdata[15:0]) & trap_pkg::TFR_MASK);
  endproperty
  a_wr_wins: assert property (p_wr_wins) else $error("write lost"); // see RULE_24
  property p_ovf_flag;
    @(posedge clk) disable iff (!rstn)
      ovf_ev && !tfr_wr |=> tfr_ff[trap_pkg::OVF_BIT] [*1] ##1 1'b1;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow lost"); // see RULE_16
  property p_flag_retrap;
    @(posedge clk) disable iff (!rstn)
      boundary && lvl_ff == trap_pkg::LVL_IDLE && b_pend && !a_pend
      |=> s_hw_entry ##0 trap_vec == trap_pkg::VEC_CLSB;
  endproperty
  a_flag_retrap: assert property (p_flag_retrap) else $error("flag no trap"); // see RULE_08
endmodule
`default_nettype wire

// >>> verification/cpu_trap_unit_tb.sv
// self-checking testbench for the trap unit
`timescale 1ns/1ns
`default_nettype none
module cpu_trap_unit_tb;
  // ******************************************
  // signals and constants
  // ******************************************
  localparam logic [15:0] TRAP_FLAG_REGISTER = trap_pkg::TFR_ADDR;
  localparam logic [15:0] STA = trap_pkg::STAT_ADDR;
  localparam logic [32:0] ALL = '1;
  localparam logic [32:0] NOIP = 33'h1_FFFF_0000;
  localparam logic [32:0] NOCAN = 33'h1_7FFF_FFFF;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, nmi_n_pin, boundary;
  logic        seg_en, sw_trap, ret_handler, sp_dec, sp_inc, sp_arith, undef_op, prot_instr;
  logic        word_access, branch, ext_access, trap_go, trap_hw, trap_push_csp, trap_raise;
  logic        trap_cancel, ret_go, ret_pop_csp;
  logic [15:0] paddr, ip_cur, ip_next, ip_next2, sp_new, stack_low_limit, stack_high_limit;
  logic [15:0] prot_word1, prot_word2, oper_addr, branch_target, trap_ip;
  logic [31:0] pwdata, prdata;
  logic [1:0]  bus_type_field;
  logic [6:0]  trap_num;
  logic [8:0]  trap_vec;
  logic [3:0]  trap_prio;
  int          n_errors, compares;
  int          bitpos [8] = '{15, 14, 13, 7, 3, 2, 1, 0};

  cpu_trap_unit cpu_trap_unit_i (
    .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .nmi_n_pin, .boundary, .seg_en, .bus_type_field, .ip_cur, .ip_next, .ip_next2,
    .sw_trap, .trap_num, .ret_handler, .sp_dec, .sp_inc, .sp_arith, .sp_new,
    .stack_low_limit, .stack_high_limit, .undef_op, .prot_instr, .prot_word1,
    .prot_word2, .word_access, .oper_addr, .branch, .branch_target, .ext_access,
    .trap_go, .trap_hw, .trap_vec, .trap_ip, .trap_push_csp, .trap_raise, .trap_prio,
    .trap_cancel, .ret_go, .ret_pop_csp
  );

  // clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ******************************************
  // compare, verdict and bus tasks
  // ******************************************
  task automatic print_verdict();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // masked compare, some entry fields are left open
  task automatic chk_trap(input logic [32:0] got, input logic [32:0] exp, input logic [32:0] m);
    compares++;
    if ((got & m) !== (exp & m)) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; only the watchdog ends a wait for pready
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk_val(rd, exp);
    chk_val({31'h0, err}, {31'h0, a != TRAP_FLAG_REGISTER && a != STA});
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  // ******************************************
  // stimulus and reference model
  // ******************************************
  // fresh random context; ips kept even so odd targets stand out
  task automatic new_ctx();
    logic [7:0] op;
    op = 8'($urandom());
    ip_cur <= 16'($urandom()) & 16'hFFFE;
    ip_next <= 16'($urandom()) & 16'hFFFE;
    ip_next2 <= 16'($urandom()) & 16'hFFFE;
    seg_en <= 1'($urandom());
    sp_arith <= 1'($urandom());
    stack_low_limit <= 16'h1000 + (16'($urandom()) & 16'h3FFE);
    stack_high_limit <= 16'h8000 + (16'($urandom()) & 16'h3FFE);
    oper_addr <= 16'($urandom()) | 16'h0001;
    branch_target <= 16'($urandom()) | 16'h0001;
    prot_word1 <= {op, op};
    prot_word2 <= {op, op};
    bus_type_field <= trap_pkg::BUS_NONE;
  endtask

  // raise one hardware source; pin held low long enough for the synchroniser
  task automatic fire(input int k);
    @(posedge clk);
    case (k)
      0: nmi_n_pin <= 1'b0;
      1: begin
        sp_dec <= 1'b1;
        sp_new <= stack_low_limit - 16'h0002;
      end
      2: begin
        sp_inc <= 1'b1;
        sp_new <= stack_high_limit + 16'h0002;
      end
      3: undef_op <= 1'b1;
      4: prot_instr <= 1'b1;
      5: word_access <= 1'b1;
      6: branch <= 1'b1;
      default: ext_access <= 1'b1;
    endcase
    @(posedge clk);
    {sp_dec, sp_inc, undef_op, prot_instr, word_access, branch, ext_access} <= 7'h00;
    repeat (5) @(posedge clk);
    nmi_n_pin <= 1'b1;
  endtask

  function automatic logic [32:0] mk(input logic [8:0] v, input logic c, input logic [15:0] ip);
    return {1'b1, c, seg_en, 1'b1, trap_pkg::PRIO_MAX, v, ip};
  endfunction

  function automatic logic [32:0] exp_hw(input int k);
    logic [15:0] ip;
    logic [8:0]  v;
    ip = (k == 3 || k == 4) ? ip_cur : (k == 6) ? branch_target :
         ((k == 1 || k == 2) && sp_arith) ? ip_next2 : ip_next;
    v = (k == 0) ? trap_pkg::VEC_NMI : (k == 1) ? trap_pkg::VEC_OVF :
        (k == 2) ? trap_pkg::VEC_UNF : trap_pkg::VEC_CLSB;
    return mk(v, k == 3 || k == 4, ip);
  endfunction

  // opens boundary and waits a bounded time for an entry
  task automatic wait_go(output logic [32:0] got, output logic found);
    int n;
    boundary <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (trap_go !== 1'b1 && n < 12);
    found = (trap_go === 1'b1);
    got = {trap_hw, trap_cancel, trap_push_csp, trap_raise, trap_prio, trap_vec, trap_ip};
    boundary <= 1'b0;
  endtask

  task automatic ret_chk();
    int n;
    @(posedge clk);
    ret_handler <= 1'b1;
    @(posedge clk);
    ret_handler <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ret_go !== 1'b1 && n < 6);
    chk_val({30'h0, ret_go, ret_pop_csp}, {30'h0, 1'b1, seg_en});
  endtask

  // watchdog, far beyond the few hundred cycles of the run
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict();
  end

  // ******************************************
  // main sequence
  // ******************************************
  initial begin
    logic [32:0] got;
    logic        found;
    logic [31:0] w;
    int          k;
    {rstn, psel, penable, pwrite, boundary, seg_en, sw_trap, ret_handler} = 8'h00;
    {sp_dec, sp_inc, sp_arith, undef_op, prot_instr, word_access, branch, ext_access} = 8'h00;
    {paddr, ip_cur, ip_next, ip_next2, sp_new, stack_low_limit, stack_high_limit} = '0;
    {prot_word1, prot_word2, oper_addr, branch_target, pwdata, trap_num} = '0;
    nmi_n_pin = 1'b1;
    bus_type_field = trap_pkg::BUS_NONE;
    n_errors = 0;
    compares = 0;
    k = $urandom(32'h6301);
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(TRAP_FLAG_REGISTER, 32'h0);
    rd_chk(STA, 32'h1);
    rd_chk(16'h0000, 32'h0);
    $display("test reset done");
    // every hardware source alone
    for (k = 0; k < 8; k++) begin
      new_ctx();
      fire(k);
      rd_chk(TRAP_FLAG_REGISTER, 32'h1 << bitpos[k]);
      wait_go(got, found);
      chk_trap(got, exp_hw(k), ALL);
      rd_chk(STA, (k < 3) ? 32'h4 : 32'h2);
      wr(TRAP_FLAG_REGISTER, 32'h0);
      ret_chk();
    end
    $display("test hw sources done");
    // well-formed accesses raise nothing
    new_ctx();
    @(posedge clk);
    bus_type_field <= 2'h1;
    oper_addr <= 16'h0F00;
    branch_target <= 16'h0F02;
    prot_word1 <= 16'h5AA5;
    prot_word2 <= 16'hA5A5;
    for (k = 4; k < 8; k++) fire(k);
    wait_go(got, found);
    chk_val({31'h0, found}, 32'h0);
    rd_chk(TRAP_FLAG_REGISTER, 32'h0);
    $display("test legal accesses done");
    // software-set flags, reserved bits, class A order, re-trap
    new_ctx();
    w = {16'h0, 16'($urandom()) | 16'h0001};
    wr(TRAP_FLAG_REGISTER, w);
    rd_chk(TRAP_FLAG_REGISTER, w & {16'h0, trap_pkg::TFR_MASK});
    wait_go(got, found);
    chk_trap(got, mk(w[15] ? trap_pkg::VEC_NMI : w[14] ? trap_pkg::VEC_OVF :
             w[13] ? trap_pkg::VEC_UNF : trap_pkg::VEC_CLSB, 1'b0, 16'h0),
             NOIP & NOCAN);
    wr(TRAP_FLAG_REGISTER, 32'h0);
    ret_chk();
    wr(TRAP_FLAG_REGISTER, 32'h6000);
    wait_go(got, found);
    chk_trap(got, mk(trap_pkg::VEC_OVF, 1'b0, 16'h0), NOIP);
    wr(TRAP_FLAG_REGISTER, 32'h2000);
    ret_chk();
    wait_go(got, found);
    chk_trap(got, mk(trap_pkg::VEC_UNF, 1'b0, 16'h0), NOIP);
    wr(TRAP_FLAG_REGISTER, 32'h0);
    ret_chk();
    $display("test software flags done");
    // nesting: A over B, B held during A
    new_ctx();
    fire(3);
    wait_go(got, found);
    fire(0);
    wait_go(got, found);
    chk_trap(got, mk(trap_pkg::VEC_NMI, 1'b0, ip_next), ALL);
    rd_chk(STA, 32'h8);
    fire(5);
    wait_go(got, found);
    chk_val({31'h0, found}, 32'h0);
    rd_chk(TRAP_FLAG_REGISTER, 32'h8084);
    wr(TRAP_FLAG_REGISTER, 32'h0004);
    ret_chk();
    ret_chk();
    wait_go(got, found);
    chk_trap(got, mk(trap_pkg::VEC_CLSB, 1'b0, ip_next), ALL);
    wr(TRAP_FLAG_REGISTER, 32'h0);
    ret_chk();
    $display("test nesting done");
    // nmi together with an undefined opcode
    new_ctx();
    @(posedge clk);
    nmi_n_pin <= 1'b0;
    fire(3);
    rd_chk(TRAP_FLAG_REGISTER, 32'h8080);
    wait_go(got, found);
    chk_trap(got, mk(trap_pkg::VEC_NMI, 1'b0, ip_cur), NOCAN);
    wr(TRAP_FLAG_REGISTER, 32'h0080);
    ret_chk();
    wait_go(got, found);
    chk_trap(got, mk(trap_pkg::VEC_CLSB, 1'b1, ip_cur), ALL);
    wr(TRAP_FLAG_REGISTER, 32'h0);
    ret_chk();
    $display("test coincident traps done");
    // software traps, both ends of the number range
    for (k = 0; k < 4; k++) begin
      new_ctx();
      @(posedge clk);
      sw_trap <= 1'b1;
      boundary <= 1'b1;
      trap_num <= (k == 0) ? 7'h00 : (k == 1) ? 7'h7F : 7'($urandom());
      @(posedge clk);
      sw_trap <= 1'b0;
      wait_go(got, found);
      chk_trap(got, {2'b00, seg_en, 5'h00, trap_num, 2'b00, 16'h0000}, NOIP);
      rd_chk(TRAP_FLAG_REGISTER, 32'h0);
      ret_chk();
    end
    $display("test software traps done");
    print_verdict();
  end
endmodule
`default_nettype wire
